/* rtl/amv_top.sv */
// Purpose: address map decode and interrupt vector selection
// Assumes: cpu address is synchronous to clk_i; axi4-lite register port
// Notes: trap wins over all others; the other vectors are given lowest-address-first priority
// Notes on behaviour
// - pins keep reset defaults while reset held
// - decode full 64k space from 16-bit address
// - register area, ram, program regions
// - stack confined to 0100h..013fh
// - top addresses hold reset and irq vectors
// - internal irqs vector fff0..fff7, no halt exit
// - eight external lines, each gated by its enable bit, share fff8 and wake
// - usb end-suspend at fffa, wakes halt
// - trap at fffc, unmaskable, no halt exit
// - masked requests stay pending until unmasked
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module amv_top import amv_pkg::*; #(
  parameter int RAM_SIZE = RAM_BYTES,
  parameter int PROG_SIZE = PROG_BYTES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic vec_ack_i,
  input wire logic trap_i,
  input wire logic usb_irq_i,
  input wire logic serial_irq_i,
  input wire logic twi_irq_i,
  input wire logic timer_irq_i,
  input wire logic usb_wake_i,
  input wire logic [7:0] ext_irq_i,
  output logic [2:0] region_o,
  output logic reserved_o,
  output logic vec_req_o,
  output logic [15:0] vec_addr_o,
  output logic halt_o,
  output logic [7:0] ext_irq_en_o,
  output logic irq_o,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam logic [15:0] RAM_END = 16'(32'(RAM_BASE) + RAM_SIZE - 1);
  localparam logic [15:0] PROG_BASE = 16'(32'h10000 - PROG_SIZE);

  // region of a cpu address; reserved where nothing is mapped
  function automatic amv_region_t decode(input logic [15:0] a);
    if (a <= REG_LAST) return REG_AREA;
    if (a >= STACK_LO && a <= STACK_HI) return STACK_AREA;
    if (a >= RAM_BASE && a <= RAM_END) return RAM_AREA;
    if (a >= VEC_USB) return VEC_AREA;
    if (a >= PROG_BASE) return PROG_AREA;
    return RSVD_AREA;
  endfunction

  amv_region_t region_d;
  logic [7:0] ext_ctrl;
  logic [6:0] pend_q, stat_q, mask_q, raw;
  logic mask_flag_q, halt_q;
  amv_vec_t vec_d, vec_q;

  // decoded region is registered; reserved is flagged, not blocked
  always_comb region_d = decode(cpu_addr_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      region_o <= 3'(REG_AREA);
      reserved_o <= 1'b0;
    end else begin
      region_o <= 3'(region_d);
      reserved_o <= (region_d == RSVD_AREA);
    end
  end

  // raw request vector; external lines gated by their enable bits
  always_comb begin
    raw = '0;
    raw[SRC_USB] = usb_irq_i;
    raw[SRC_SERIAL] = serial_irq_i;
    raw[SRC_TWI] = twi_irq_i;
    raw[SRC_TIMER] = timer_irq_i;
    raw[SRC_EXT] = |(ext_irq_i & ext_ctrl);
    raw[SRC_WAKE] = usb_wake_i;
    raw[SRC_TRAP] = trap_i;
  end

  // winning vector: trap ignores the mask, others wait while it is set
  always_comb begin
    vec_d = '0;
    if (pend_q[SRC_TRAP]) begin
      vec_d = '{valid: 1'b1, addr: VEC_TRAP, src: 3'(SRC_TRAP)};
    end else if (!mask_flag_q) begin
      for (int i = SRC_WAKE; i >= 0; i--) begin
        if (pend_q[i]) begin
          vec_d = '{valid: 1'b1, addr: 16'(VEC_USB + 16'(2 * i)), src: 3'(i)};
        end
      end
    end
  end

  // pending latch; set wins over the acknowledge clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~((vec_ack_i && vec_q.valid) ? 7'(1 << vec_q.src) : 7'h00))
        | raw;
    end
  end

  // vector output; reset vector is shown while reset is held
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vec_q <= '{valid: 1'b1, addr: VEC_RESET, src: 3'h7};
    end else if (vec_ack_i && vec_q.valid) begin
      vec_q <= '0; // one cycle gap before next vector
    end else if (!vec_q.valid) begin
      // a shown vector stands until fetched, so a slow cpu never sees it vanish
      vec_q <= vec_d;
    end
  end
  assign vec_req_o = vec_q.valid;
  assign vec_addr_o = vec_q.addr;

  // mask flag and halt state; entry sets the mask like the cpu does
  logic cpu_wr;
  logic [31:0] wdata_q;
  logic [7:0] waddr_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_flag_q <= 1'b1;
      halt_q <= 1'b0;
    end else begin
      if (vec_ack_i && vec_q.valid) mask_flag_q <= 1'b1;
      else if (cpu_wr) mask_flag_q <= wdata_q[CC_MASK_BIT];
      if (raw[SRC_EXT] || raw[SRC_WAKE]) halt_q <= 1'b0;
      else if (cpu_wr && wdata_q[CC_HALT_BIT]) halt_q <= 1'b1;
    end
  end
  assign halt_o = halt_q;

  // axi4-lite write: take aw and w in either order, answer after both
  logic aw_have, w_have, wr_go, rd_go;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      // ready mirrors an empty holding slot, registered so the bus sees a flop
      s_axi_awready <= !aw_have;
      s_axi_wready <= !w_have;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        waddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        wdata_q <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (waddr_q inside {A_EXT_CTRL, A_EVT_STAT, A_EVT_MASK, A_CPU_CTRL})
          ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign wr_go = aw_have && w_have && !s_axi_bvalid;
  assign cpu_wr = wr_go && waddr_q == A_CPU_CTRL;

  // sticky event status; write one clears, new events win
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= '0;
      mask_q <= '0;
    end else begin
      stat_q <= (stat_q & ~((wr_go && waddr_q == A_EVT_STAT) ? wdata_q[6:0] : 7'h00)) | raw;
      if (wr_go && waddr_q == A_EVT_MASK) mask_q <= wdata_q[6:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) irq_o <= 1'b0;
    else irq_o <= |(stat_q & mask_q);
  end

  // external control byte lives in the bank; enables follow it
  logic [7:0] bank_rd;
  amv_regbank #(.DEPTH(4)) u_bank (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(wr_go && waddr_q == A_EXT_CTRL),
    .waddr_i(2'b00),
    .wdata_i(wdata_q[7:0]),
    .raddr_i(2'b00),
    .rdata_o(bank_rd),
    .word0_o(ext_ctrl)
  );

  // enables held at default until reset release
  always_ff @(posedge clk_i) begin
    if (rst_i) ext_irq_en_o <= EXT_CTRL_RST;
    else ext_irq_en_o <= ext_ctrl;
  end

  // axi4-lite read: two-cycle answer so the bank read can settle
  logic rd_wait;
  logic [7:0] raddr_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_wait <= 1'b0;
      raddr_q <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !rd_wait && !s_axi_rvalid;
      if (rd_go) begin
        rd_wait <= 1'b1;
        raddr_q <= s_axi_araddr;
        s_axi_arready <= 1'b0;
      end
      if (rd_wait) begin
        rd_wait <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        unique case (raddr_q)
          A_EXT_CTRL: s_axi_rdata <= {24'h0, bank_rd};
          A_PEND: s_axi_rdata <= {25'h0, pend_q};
          A_EVT_STAT: s_axi_rdata <= {25'h0, stat_q};
          A_EVT_MASK: s_axi_rdata <= {25'h0, mask_q};
          A_CPU_CTRL: s_axi_rdata <= {30'h0, halt_q, mask_flag_q};
          A_VEC_STAT: s_axi_rdata <= {15'h0, vec_q.valid, vec_q.addr};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready && s_axi_rvalid) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1; // free again once the answer is taken
      end
    end
  end
  assign rd_go = s_axi_arvalid && s_axi_arready;

  // checks
  a_trap_unmasked: assert property (@(posedge clk_i) disable iff (rst_i)
    pend_q[SRC_TRAP] && !(vec_ack_i && vec_q.valid) |=> vec_q.valid)
    else $error("pending trap gave no vector");
  a_mask_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(mask_flag_q) && !$past(vec_q.valid) && !$past(pend_q[SRC_TRAP]) |-> !vec_q.valid)
    else $error("vector issued while masked");
  a_pend_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    pend_q[SRC_TIMER] && mask_flag_q |=> pend_q[SRC_TIMER])
    else $error("masked request lost");
  a_wake_ext: assert property (@(posedge clk_i) disable iff (rst_i)
    halt_q && raw[SRC_EXT] |=> !halt_q)
    else $error("external irq did not wake");
  a_wake_usb: assert property (@(posedge clk_i) disable iff (rst_i)
    raw[SRC_WAKE] |=> !halt_q)
    else $error("usb wake did not end halt");
  a_timer_nowake: assert property (@(posedge clk_i) disable iff (rst_i)
    halt_q && !raw[SRC_EXT] && !raw[SRC_WAKE] && !cpu_wr |=> halt_q)
    else $error("halt left without wake source");
  a_reset_vec: assert property (@(posedge clk_i)
    rst_i |=> vec_q.addr == VEC_RESET && vec_q.valid && !halt_q)
    else $error("reset vector wrong");
  a_stack_map: assert property (@(posedge clk_i) disable iff (rst_i)
    cpu_addr_i >= STACK_LO && cpu_addr_i <= STACK_HI |=> region_o == 3'(STACK_AREA))
    else $error("stack window misdecoded");
  a_vec_map: assert property (@(posedge clk_i) disable iff (rst_i)
    vec_q.valid |-> vec_q.addr >= VEC_USB && vec_q.addr[0] == 1'b0)
    else $error("vector outside top area");
  a_vec_stands: assert property (@(posedge clk_i) disable iff (rst_i)
    vec_q.valid && !vec_ack_i |=> vec_q.valid && $stable(vec_q.addr))
    else $error("vector dropped before fetch");
  a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    |(stat_q & mask_q) |=> irq_o)
    else $error("unmasked event gave no interrupt");
endmodule
`default_nettype wire

/* shared/amv_pkg.sv */
// Purpose: constants and types for the address map and vector decode block
// Assumes: 16-bit cpu addresses, 8-bit data
// Notes: register offsets are axi byte addresses
package amv_pkg;
  // cpu address map
  localparam logic [15:0] REG_BASE = 16'h0000;
  localparam logic [15:0] REG_LAST = 16'h00bf;
  localparam logic [15:0] RAM_BASE = 16'h00c0;
  localparam logic [15:0] STACK_LO = 16'h0100;
  localparam logic [15:0] STACK_HI = 16'h013f;
  localparam int RAM_BYTES = 512;
  localparam int PROG_BYTES = 16384;
  localparam logic [15:0] EXT_CTRL_CPU_OFFS = 16'h0008;
  // vector addresses (low byte of each pair)
  localparam logic [15:0] VEC_USB = 16'hfff0;
  localparam logic [15:0] VEC_SERIAL = 16'hfff2;
  localparam logic [15:0] VEC_TWI = 16'hfff4;
  localparam logic [15:0] VEC_TIMER = 16'hfff6;
  localparam logic [15:0] VEC_EXT = 16'hfff8;
  localparam logic [15:0] VEC_WAKE = 16'hfffa;
  localparam logic [15:0] VEC_TRAP = 16'hfffc;
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  // source bit positions in status and mask
  localparam int SRC_USB = 0;
  localparam int SRC_SERIAL = 1;
  localparam int SRC_TWI = 2;
  localparam int SRC_TIMER = 3;
  localparam int SRC_EXT = 4;
  localparam int SRC_WAKE = 5;
  localparam int SRC_TRAP = 6;
  localparam int NSRC = 7;
  // axi register byte addresses
  localparam logic [7:0] A_EXT_CTRL = 8'h08;
  localparam logic [7:0] A_PEND = 8'h40;
  localparam logic [7:0] A_EVT_STAT = 8'h44;
  localparam logic [7:0] A_EVT_MASK = 8'h48;
  localparam logic [7:0] A_CPU_CTRL = 8'h4c;
  localparam logic [7:0] A_VEC_STAT = 8'h50;
  localparam logic [7:0] EXT_CTRL_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // cpu control bits
  localparam int CC_MASK_BIT = 0;
  localparam int CC_HALT_BIT = 1;

  typedef enum logic [2:0] {
    REG_AREA = 3'b000,
    RAM_AREA = 3'b001,
    STACK_AREA = 3'b010,
    PROG_AREA = 3'b011,
    VEC_AREA = 3'b100,
    RSVD_AREA = 3'b101
  } amv_region_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [2:0] src;
  } amv_vec_t;
endpackage

/* rtl/amv_regbank.sv */
// Purpose: byte register bank for the external interrupt control bytes
// Assumes: one write port, registered read
// Notes: read data comes out of a flip-flop
`timescale 1ns/1ps
`default_nettype none
module amv_regbank import amv_pkg::*; #(
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic [7:0] rdata_o,
  output logic [7:0] word0_o
);
  logic [7:0] mem_q [DEPTH];

  // writes, all bytes reset to the documented value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= EXT_CTRL_RST;
      end
    end else if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // registered read port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= mem_q[raddr_i];
    end
  end

  assign word0_o = mem_q[0];
endmodule
`default_nettype wire

/* verif/amv_cpu_model.sv */
// Purpose: cpu core stand-in that fetches pending vectors
// Assumes: level vector request, one-cycle ack pulse
// Notes: fetch delay is picked by the bench per flush
`timescale 1ns/1ps
`default_nettype none
module amv_cpu_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic vec_req_i,
  input wire logic [3:0] delay_i,
  output logic vec_ack_o
);
  logic [3:0] wait_q;
  // fetch once the delay is spent; a slow cpu shows queued winners hold
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vec_ack_o <= 1'b0;
      wait_q <= 4'h0;
    end else if (vec_ack_o) begin
      vec_ack_o <= 1'b0; // single pulse, never a level
    end else if (vec_req_i) begin
      if (wait_q >= delay_i) begin
        vec_ack_o <= 1'b1;
        wait_q <= 4'h0;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* verif/amv_top_tb.sv */
// Purpose: self-checking bench for the map decode and vector block
// Assumes: axi4-lite master tasks, cpu model fetches vectors
// Notes: vector results are checked from a queue of expected addresses
`timescale 1ns/1ps
`default_nettype none
module amv_top_tb import amv_pkg::*;;
  logic clk_i, rst_i, vec_ack_i, trap_i, usb_wake_i;
  logic [3:0] int_irq;
  logic [15:0] cpu_addr_i, vec_addr_o;
  logic [7:0] ext_irq_i, ext_irq_en_o, s_axi_awaddr, s_axi_araddr, en;
  logic [2:0] region_o;
  logic reserved_o, vec_req_o, halt_o, irq_o;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, rnd;
  logic [3:0] s_axi_wstrb, dly;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] vq[$];
  logic [15:0] ra[9] = '{16'h0000, 16'h00bf, 16'h00c0, 16'h0100, 16'h013f, 16'h0140,
    16'h02c0, 16'hc000, 16'hfffe};
  logic [2:0] rg[9] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h2, 3'h1, 3'h5, 3'h3, 3'h4};
  int error_cnt = 0, check_count = 0, seed = 62274;

  amv_top i_amv_top (.clk_i(clk_i), .rst_i(rst_i), .cpu_addr_i(cpu_addr_i),
    .vec_ack_i(vec_ack_i), .trap_i(trap_i), .usb_irq_i(int_irq[0]), .serial_irq_i(int_irq[1]),
    .twi_irq_i(int_irq[2]), .timer_irq_i(int_irq[3]), .usb_wake_i(usb_wake_i),
    .ext_irq_i(ext_irq_i), .region_o(region_o), .reserved_o(reserved_o),
    .vec_req_o(vec_req_o), .vec_addr_o(vec_addr_o), .halt_o(halt_o),
    .ext_irq_en_o(ext_irq_en_o), .irq_o(irq_o), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  amv_cpu_model i_amv_cpu_model (.clk_i(clk_i), .rst_i(rst_i), .vec_req_i(vec_req_o),
    .delay_i(dly), .vec_ack_o(vec_ack_i));

  // 10 mhz clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // oldest expected vector is compared at each fetch
  task automatic chk_vec();
    check_count++;
    if (vq.size() == 0 || vec_addr_o !== vq[0]) begin
      error_cnt++;
      $display("wrong value at %0t: vector %h", $time, vec_addr_o);
    end
    if (vq.size() > 0) void'(vq.pop_front());
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // ready is sampled at the negedge, stable until the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    logic aw, w, ta, tw, tb;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(negedge clk_i);
      ta = s_axi_awready & aw;
      tw = s_axi_wready & w;
      @(posedge clk_i);
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (tw) begin
        s_axi_wvalid <= 1'b0;
        w = 1'b0;
      end
    end
    do begin
      @(negedge clk_i);
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_i);
    end while (!tb);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    logic t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge clk_i);
      t = s_axi_arready;
      @(posedge clk_i);
    end while (!t);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge clk_i);
      t = s_axi_rvalid;
      v = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_i);
    end while (!t);
  endtask

  task automatic wait_vec();
    for (int n = 0; n < 60 && vq.size() > 0; n++) tick(1);
    chk(32'(vq.size()), 0, "vector missing");
  endtask

  // clear the cpu mask flag, expect one winner fetched
  task automatic flush(input logic [15:0] a);
    rnd = $random(seed);
    dly <= rnd[3:0];
    vq.push_back(a);
    wr(A_CPU_CTRL, 32'h0, rs);
    wait_vec();
  endtask

  // vector fetch monitor
  always @(posedge clk_i) begin
    if (!rst_i && vec_req_o && vec_ack_i) chk_vec();
  end

  // watchdog
  initial begin
    tick(20000);
    error_cnt++;
    end_sim();
  end

  initial begin
    {trap_i, usb_wake_i, int_irq, ext_irq_i, cpu_addr_i, dly} = '0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_araddr, s_axi_arvalid} = '0;
    // answer readies stay high, so every response is taken at its first edge
    {s_axi_bready, s_axi_rready} = 2'b11;
    s_axi_wstrb = 4'hf;
    rst_i = 1'b1;
    vq.push_back(VEC_RESET);
    tick(5);
    chk(ext_irq_en_o, EXT_CTRL_RST, "enables in reset");
    rst_i <= 1'b0;
    wait_vec();
    rd(A_EXT_CTRL, d, rs);
    chk(d[7:0], EXT_CTRL_RST, "ext ctrl reset");
    rnd = $random(seed);
    en = (rnd[7:0] | 8'h01) & 8'hfd;
    wr(A_EXT_CTRL, {24'h0, en}, rs);
    chk(rs, RESP_OKAY, "write resp");
    rd(A_EXT_CTRL, d, rs);
    chk(d[7:0], en, "ext ctrl readback");
    chk(ext_irq_en_o, en, "line enables");
    rd(8'h3c, d, rs);
    chk(rs, RESP_SLVERR, "unmapped read");
    wr(8'h3c, 32'h1, rs);
    chk(rs, RESP_SLVERR, "unmapped write");
    for (int i = 0; i < 9; i++) begin
      cpu_addr_i <= ra[i];
      tick(2);
      chk(region_o, rg[i], "region");
      chk(reserved_o, rg[i] == 3'h5, "reserved flag");
    end
    // all four internal sources at once while the mask flag is set
    int_irq <= 4'hf;
    tick(1);
    int_irq <= 4'h0;
    tick(8);
    chk(vec_req_o, 1'b0, "masked request");
    rd(A_PEND, d, rs);
    chk(d[3:0], 4'hf, "pending kept");
    rd(A_VEC_STAT, d, rs);
    chk(d[16:0], 17'h0, "no vector masked");
    for (int i = 0; i < 4; i++) flush(VEC_USB + 16'(2 * i));
    wr(A_EVT_MASK, 32'h8, rs);
    tick(2);
    chk(irq_o, 1'b1, "irq on");
    wr(A_EVT_STAT, 32'h8, rs);
    tick(2);
    chk(irq_o, 1'b0, "irq cleared");
    rd(A_EVT_STAT, d, rs);
    chk(d[6:0], 7'h07, "status sticky");
    wr(A_EVT_MASK, 32'h0, rs);
    // halt: internal, disabled line and trap keep it, enabled line and wake end it
    wr(A_CPU_CTRL, 32'h3, rs);
    int_irq <= 4'h8;
    ext_irq_i <= 8'h02;
    tick(1);
    {int_irq, ext_irq_i} <= '0;
    tick(4);
    chk(halt_o, 1'b1, "halt held");
    rd(A_CPU_CTRL, d, rs);
    chk(d[1:0], 2'b11, "cpu control");
    trap_i <= 1'b1;
    vq.push_back(VEC_TRAP);
    tick(1);
    trap_i <= 1'b0;
    wait_vec();
    chk(halt_o, 1'b1, "trap keeps halt");
    ext_irq_i <= 8'h01;
    tick(1);
    ext_irq_i <= 8'h00;
    tick(3);
    chk(halt_o, 1'b0, "line wake");
    wr(A_CPU_CTRL, 32'h3, rs);
    usb_wake_i <= 1'b1;
    tick(1);
    usb_wake_i <= 1'b0;
    tick(3);
    chk(halt_o, 1'b0, "usb wake");
    flush(VEC_TIMER);
    flush(VEC_EXT);
    flush(VEC_WAKE);
    end_sim();
  end
endmodule
`default_nettype wire
